/* File: verilog/suc_host.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module suc_host
   import suc_pkg::*;
(
   // clock, enable, reset
   input  wire logic        core_clk,
   input  wire logic        ce,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // serial pins to the synthesizer
   output logic             syn_clk,
   output logic             syn_data,
   output logic             syn_latch
);
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_FETCH = 6'b000010,
      ST_WAIT  = 6'b000100,
      ST_SEND  = 6'b001000,
      ST_HOLD  = 6'b010000,
      ST_NEXT  = 6'b100000
   } suc_st_t;
   typedef struct packed {
      suc_st_t     st;
      logic [3:0]  idx;
      logic        single;
      logic        done;
      logic        badres;
      logic [31:0] word;
      logic        go;
      logic        wreq;
      logic [31:0] rdata;
      logic        sck;
      logic        sd;
      logic        le;
   } suc_state_t;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   suc_state_t  s_reg;
   suc_state_t  s_next;
   logic [1:0]  rst_sync_reg;
   logic        rst_sync_b;
   logic        sh_busy;
   logic        sh_clk;
   logic        sh_data;
   logic        sh_latch;
   logic [31:0] mem_rdata;
   logic        mem_we;
   logic [3:0]  mem_waddr;
   logic        acc;
   logic [31:0] shaped;
   // ----------------------------------------
   // reset release
   // ----------------------------------------
   // kept apart from the state struct: it lives on the raw reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= 2'b00;
      end else if (ce) begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_sync_reg[1];
   // ----------------------------------------
   // word image store
   // ----------------------------------------
   // software loads images; writes only land while no sequence runs
   assign acc       = (avs_read | avs_write) & s_reg.wreq;
   assign mem_we    = acc & avs_write & (avs_address == SUC_ADDR_WDATA)
                      & (s_reg.st == ST_IDLE);
   assign mem_waddr = s_reg.idx;
   suc_word_mem u_mem (
      .clk   (core_clk),
      .ce    (ce),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (avs_writedata),
      .raddr (s_reg.idx),
      .rdata (mem_rdata)
   );
   // ----------------------------------------
   // shaping of each word before it leaves
   // ----------------------------------------
   always_comb begin
      shaped = mem_rdata;
      case (s_reg.idx)
         SUC_SEL_R7: begin
            // keeps 25 and 9:4; forces reserved pattern
            shaped = (mem_rdata & SUC_R7_KEEP) | SUC_R7_FORCE;
         end
         SUC_SEL_R8:  shaped = SUC_FIXED_R8;
         SUC_SEL_R9:  shaped = mem_rdata & SUC_R9_KEEP;
         SUC_SEL_R10: begin
            shaped = (mem_rdata & SUC_R10_KEEP) | SUC_R10_FORCE;
         end
         SUC_SEL_R11: shaped = SUC_FIXED_R11;
         SUC_SEL_R12: begin
            shaped = (mem_rdata & SUC_R12_KEEP) | SUC_R12_FORCE;
         end
         default:     shaped = mem_rdata;
      endcase
      shaped[3:0] = s_reg.idx;
   end
   // ----------------------------------------
   // sequencer and bus slave
   // ----------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.go       = 1'b0;
      s_next.wreq     = 1'b1;
      s_next.sck      = sh_clk;
      s_next.sd       = sh_data;
      s_next.le       = sh_latch;
      if (acc) begin
         s_next.wreq  = 1'b0;
         s_next.rdata = SUC_DEAD_DATA;
         if (avs_read) begin
            case (avs_address)
               SUC_ADDR_STATUS: begin
                  s_next.rdata[SUC_ST_BUSY]   = (s_reg.st != ST_IDLE);
                  s_next.rdata[SUC_ST_DONE]   = s_reg.done;
                  s_next.rdata[SUC_ST_BADRES] = s_reg.badres;
               end
               SUC_ADDR_WIDX:  s_next.rdata[3:0] = s_reg.idx;
               SUC_ADDR_WDATA: s_next.rdata = mem_rdata;
               default:        s_next.rdata = SUC_DEAD_DATA;
            endcase
         end else if (s_reg.st == ST_IDLE) begin
            case (avs_address)
               SUC_ADDR_WIDX: s_next.idx = avs_writedata[3:0];
               SUC_ADDR_CTRL: begin
                  if (avs_writedata[SUC_CTRL_START]) begin
                     s_next.single = avs_writedata[SUC_CTRL_SINGLE];
                     // full load starts at the top word
                     if (!avs_writedata[SUC_CTRL_SINGLE]) begin
                        s_next.idx = SUC_SEL_R12;
                     end
                     s_next.done   = 1'b0;
                     s_next.badres = 1'b0;
                     s_next.st     = ST_FETCH;
                  end
               end
               default: s_next.idx = s_reg.idx;
            endcase
         end
      end
      case (s_reg.st)
         ST_IDLE:  s_next.st = s_next.st;
         ST_FETCH: s_next.st = ST_WAIT;
         ST_WAIT: begin
            // zero resync delay is illegal, so the sequence stops here
            if (s_reg.idx == SUC_SEL_R12 &&
                shaped[31:SUC_RESYNC_LSB] == 16'h0000) begin
               s_next.badres = 1'b1;
               s_next.st     = ST_IDLE;
            end else begin
               s_next.word = shaped;
               s_next.go   = 1'b1;
               s_next.st   = ST_SEND;
            end
         end
         ST_SEND: s_next.st = ST_HOLD;
         ST_HOLD: begin
            if (!sh_busy) begin
               s_next.st = ST_NEXT;
            end
         end
         ST_NEXT: begin
            // word zero last: earlier words do not retune
            if (s_reg.single || s_reg.idx == SUC_SEL_R0) begin
               s_next.done = 1'b1;
               s_next.st   = ST_IDLE;
            end else begin
               s_next.idx = s_reg.idx - 4'h1;
               s_next.st  = ST_FETCH;
            end
         end
         default: s_next.st = ST_IDLE;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_reg.st     <= ST_IDLE;
         s_reg.idx    <= 4'h0;
         s_reg.single <= 1'b0;
         s_reg.done   <= 1'b0;
         s_reg.badres <= 1'b0;
         s_reg.word   <= 32'h0;
         s_reg.go     <= 1'b0;
         s_reg.wreq   <= 1'b1;
         s_reg.rdata  <= 32'h0;
         s_reg.sck    <= 1'b0;
         s_reg.sd     <= 1'b0;
         s_reg.le     <= 1'b0;
      end else if (ce) begin
         s_reg.st     <= s_next.st;
         s_reg.idx    <= s_next.idx;
         s_reg.single <= s_next.single;
         s_reg.done   <= s_next.done;
         s_reg.badres <= s_next.badres;
         s_reg.word   <= s_next.word;
         s_reg.go     <= s_next.go;
         s_reg.wreq   <= s_next.wreq;
         s_reg.rdata  <= s_next.rdata;
         s_reg.sck    <= s_next.sck;
         s_reg.sd     <= s_next.sd;
         s_reg.le     <= s_next.le;
      end
   end
   // ----------------------------------------
   // serial engine
   // ----------------------------------------
   suc_shifter u_shift (
      .clk        (core_clk),
      .ce         (ce),
      .rst_sync_b (rst_sync_b),
      .go         (s_reg.go),
      .word       (s_reg.word),
      .busy       (sh_busy),
      .ser_clk    (sh_clk),
      .ser_data   (sh_data),
      .ser_latch  (sh_latch)
   );
   assign avs_waitrequest = s_reg.wreq;
   assign avs_readdata    = s_reg.rdata;
   assign syn_clk         = s_reg.sck;
   assign syn_data        = s_reg.sd;
   assign syn_latch       = s_reg.le;
endmodule : suc_host

/* File: verilog/suc_pkg.sv */
package suc_pkg;
   // ----------------------------------------
   // register select codes
   // ----------------------------------------
   localparam logic [3:0] SUC_SEL_R0  = 4'h0;
   localparam logic [3:0] SUC_SEL_R6  = 4'h6;
   localparam logic [3:0] SUC_SEL_R7  = 4'h7;
   localparam logic [3:0] SUC_SEL_R8  = 4'h8;
   localparam logic [3:0] SUC_SEL_R9  = 4'h9;
   localparam logic [3:0] SUC_SEL_R10 = 4'hA;
   localparam logic [3:0] SUC_SEL_R11 = 4'hB;
   localparam logic [3:0] SUC_SEL_R12 = 4'hC;
   localparam int         SUC_NUM_WORDS = 13;
   // ----------------------------------------
   // fixed words and mandatory bit patterns
   // ----------------------------------------
   localparam logic [31:0] SUC_FIXED_R8   = 32'h102D4028;
   localparam logic [31:0] SUC_FIXED_R11  = 32'h0061300B;
   localparam logic [31:0] SUC_R7_KEEP    = 32'h020003F0;
   localparam logic [31:0] SUC_R7_FORCE   = 32'h10000000;
   localparam logic [31:0] SUC_R9_KEEP    = 32'hFFFFFFF0;
   localparam logic [31:0] SUC_R10_KEEP   = 32'h00003FF0;
   localparam logic [31:0] SUC_R10_FORCE  = 32'h00C00000;
   localparam logic [31:0] SUC_R12_KEEP   = 32'hFFFF0000;
   localparam logic [31:0] SUC_R12_FORCE  = 32'h00000410;
   localparam int          SUC_RESYNC_LSB = 16;
   // ----------------------------------------
   // own register map (byte offsets)
   // ----------------------------------------
   localparam logic [3:0] SUC_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] SUC_ADDR_STATUS = 4'h4;
   localparam logic [3:0] SUC_ADDR_WIDX   = 4'h8;
   localparam logic [3:0] SUC_ADDR_WDATA  = 4'hC;
   localparam int         SUC_CTRL_START  = 0;
   localparam int         SUC_CTRL_SINGLE = 1;
   localparam int         SUC_ST_BUSY     = 0;
   localparam int         SUC_ST_DONE     = 1;
   localparam int         SUC_ST_BADRES   = 2;
   localparam logic [31:0] SUC_DEAD_DATA  = 32'h00000000;
   // ----------------------------------------
   // link timing
   // ----------------------------------------
   localparam int         SUC_CLK_MHZ     = 100;
   localparam int         SUC_HALF_NS     = 50;
   localparam int         SUC_HALF_CYC    = (SUC_HALF_NS * SUC_CLK_MHZ + 999) / 1000;
   localparam int         SUC_LE_NS       = 20;
   localparam int         SUC_LE_CYC      = (SUC_LE_NS * SUC_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] SUC_HALF_CNT    = 8'(SUC_HALF_CYC);
   localparam logic [7:0] SUC_LE_CNT      = 8'(SUC_LE_CYC);
endpackage : suc_pkg

/* File: verilog/suc_word_mem.sv */
`timescale 1ns/100ps
module suc_word_mem (
   // clock
   input  wire logic        clk,
   input  wire logic        ce,
   // write port
   input  wire logic        we,
   input  wire logic [3:0]  waddr,
   input  wire logic [31:0] wdata,
   // read port
   input  wire logic [3:0]  raddr,
   output logic      [31:0] rdata
);
   logic [31:0] mem [0:15];
   // no reset: contents are software images, loaded before start
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule : suc_word_mem

/* File: verilog/suc_shifter.sv */
`timescale 1ns/100ps
module suc_shifter
   import suc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        ce,
   input  wire logic        rst_sync_b,
   // word request
   input  wire logic        go,
   input  wire logic [31:0] word,
   output logic             busy,
   // serial pins
   output logic             ser_clk,
   output logic             ser_data,
   output logic             ser_latch
);
   typedef enum logic [3:0] {
      SH_IDLE  = 4'b0001,
      SH_LOW   = 4'b0010,
      SH_HIGH  = 4'b0100,
      SH_LATCH = 4'b1000
   } suc_sh_st_t;
   typedef struct packed {
      suc_sh_st_t  st;
      logic [31:0] sr;
      logic [5:0]  nbit;
      logic [7:0]  tmr;
      logic        sck;
      logic        sd;
      logic        le;
   } suc_sh_t;
   suc_sh_t s_reg, s_next;
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         SH_IDLE: begin
            s_next.le  = 1'b0;
            s_next.sck = 1'b0;
            if (go) begin
               s_next.sr   = word;
               s_next.sd   = word[31];
               s_next.nbit = 6'h00;
               s_next.tmr  = SUC_HALF_CNT;
               s_next.st   = SH_LOW;
            end
         end
         SH_LOW: begin
            if (s_reg.tmr > 8'h01) begin
               s_next.tmr = s_reg.tmr - 8'h01;
            end else begin
               s_next.sck = 1'b1;
               s_next.tmr = SUC_HALF_CNT;
               s_next.st  = SH_HIGH;
            end
         end
         SH_HIGH: begin
            if (s_reg.tmr > 8'h01) begin
               s_next.tmr = s_reg.tmr - 8'h01;
            end else begin
               s_next.sck  = 1'b0;
               s_next.sr   = {s_reg.sr[30:0], 1'b0};
               s_next.sd   = s_reg.sr[30];
               s_next.nbit = s_reg.nbit + 6'h01;
               s_next.tmr  = SUC_HALF_CNT;
               if (s_reg.nbit == 6'h1F) begin
                  s_next.le  = 1'b1;
                  s_next.tmr = SUC_LE_CNT;
                  s_next.st  = SH_LATCH;
               end else begin
                  s_next.st = SH_LOW;
               end
            end
         end
         SH_LATCH: begin
            if (s_reg.tmr > 8'h01) begin
               s_next.tmr = s_reg.tmr - 8'h01;
            end else begin
               s_next.le = 1'b0;
               s_next.st = SH_IDLE;
            end
         end
         default: s_next.st = SH_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_reg <= '{st: SH_IDLE, sr: 32'h0, nbit: 6'h0, tmr: 8'h0,
                    sck: 1'b0, sd: 1'b0, le: 1'b0};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end
   assign busy      = (s_reg.st != SH_IDLE) | go;
   assign ser_clk   = s_reg.sck;
   assign ser_data  = s_reg.sd;
   assign ser_latch = s_reg.le;
endmodule : suc_shifter

/* File: verif/suc_host_monitor.sv */
`timescale 1ns/100ps
module suc_host_monitor (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        ce,
   input  wire logic        rst_b,
   // avalon-mm
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest,
   // serial pins
   input  wire logic        syn_clk,
   input  wire logic        syn_data,
   input  wire logic        syn_latch
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // rise counter between latches
   // ----------------------------------------
   // a dropped or doubled bit shows as a count other than 32
   logic [5:0] rise_cnt_reg;
   logic       clk_d_reg;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rise_cnt_reg <= 6'h00;
         clk_d_reg    <= 1'b0;
      end else begin
         clk_d_reg <= syn_clk;
         if (syn_latch) begin
            rise_cnt_reg <= 6'h00;
         end else if (syn_clk && !clk_d_reg) begin
            rise_cnt_reg <= rise_cnt_reg + 6'h01;
         end
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_ack_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_ack_one: assert property (p_ack_one) else $error("answer longer than one cycle");
   property p_ack_next; ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
   property p_no_req; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
   a_no_req: assert property (p_no_req) else $error("answer without request");
   property p_word_len; $rose(syn_latch) |-> rise_cnt_reg == 6'h20; endproperty
   a_word_len: assert property (p_word_len) else $error("word not 32 clocks");
   property p_latch_two; $rose(syn_latch) |=> syn_latch ##1 !syn_latch; endproperty
   a_latch_two: assert property (p_latch_two) else $error("latch width wrong");
   property p_high_half; $rose(syn_clk) |-> syn_clk [*5] ##1 !syn_clk; endproperty
   a_high_half: assert property (p_high_half) else $error("clock high half wrong");
   property p_low_half; $fell(syn_clk) |-> !syn_clk [*5]; endproperty
   a_low_half: assert property (p_low_half) else $error("clock low half short");
   property p_data_hold; syn_clk |-> $stable(syn_data); endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
   property p_latch_clk_low; syn_latch |-> !syn_clk; endproperty
   a_latch_clk_low: assert property (p_latch_clk_low) else $error("clock high in latch");
endmodule : suc_host_monitor

/* File: verif/suc_dev_model.sv */
`timescale 1ns/100ps
module suc_dev_model (
   // clock
   input  wire logic        core_clk,
   // serial pins
   input  wire logic        syn_clk,
   input  wire logic        syn_data,
   input  wire logic        syn_latch,
   // latched word
   output logic             got,
   output logic [31:0]      word,
   // decoded controls
   output logic             out_a_en,
   output logic [1:0]       out_a_pwr,
   output logic             freq_apply
);
   // ----------------------------------------
   // shift and latch
   // ----------------------------------------
   logic [31:0] shift_reg;
   logic [31:0] regs [0:15];
   logic        clk_d;
   logic        le_d;
   logic [6:0]  lock_cfg;
   logic [31:0] cal_cfg;
   logic [9:0]  adc_cfg;
   // reference ratio until a reference word arrives
   localparam int REF_RATIO_DEFAULT = 1;
   initial begin
      clk_d      = 1'b0;
      le_d       = 1'b0;
      got        = 1'b0;
      freq_apply = 1'b0;
      word       = 32'h0;
   end
   always @(posedge core_clk) begin
      clk_d      <= syn_clk;
      le_d       <= syn_latch;
      got        <= 1'b0;
      freq_apply <= 1'b0;
      if (syn_clk && !clk_d) begin
         shift_reg <= {shift_reg[30:0], syn_data};
      end
      if (syn_latch && !le_d) begin
         regs[shift_reg[3:0]] <= shift_reg;
         word                 <= shift_reg;
         got                  <= 1'b1;
         freq_apply           <= (shift_reg[3:0] == 4'h0);
      end
   end
   assign out_a_en  = regs[6][6];
   assign out_a_pwr = regs[6][5:4];
   assign lock_cfg  = {regs[7][25], regs[7][9:4]};
   assign cal_cfg   = regs[9];
   assign adc_cfg   = regs[10][13:4];
endmodule : suc_dev_model

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import suc_pkg::*;
   logic        core_clk, ce, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, st, rd;
   logic        syn_clk, syn_data, syn_latch, m_got, m_en, m_fa;
   logic [1:0]  m_pwr;
   logic [31:0] m_word;
   logic [31:0] img [0:12];
   logic [31:0] exp_q [$];
   int          errors, checks_done, cyc, words_seen;
   initial begin
      core_clk = 1'b0; ce = 1'b1; rst_b = 1'b0; avs_address = 4'h0;
      avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
      errors = 0; checks_done = 0; cyc = 0; words_seen = 0;
   end
   always #5 core_clk = ~core_clk;
   suc_host u_dut (.core_clk(core_clk), .ce(ce), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .syn_clk(syn_clk), .syn_data(syn_data), .syn_latch(syn_latch));
   suc_dev_model u_dev (.core_clk(core_clk), .syn_clk(syn_clk), .syn_data(syn_data),
      .syn_latch(syn_latch), .got(m_got), .word(m_word), .out_a_en(m_en),
      .out_a_pwr(m_pwr), .freq_apply(m_fa));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task results();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task check(input string nm, input logic [31:0] e, input logic [31:0] a);
      checks_done++;
      if (e !== a) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, a);
      end
   endtask : check
   task bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a; avs_writedata <= d; avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_wr
   task bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a; avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd
   // polls until the run ends, cleanly or by refusal
   task wait_end(output logic [31:0] s);
      do bus_rd(SUC_ADDR_STATUS, s);
      while (s[SUC_ST_DONE] !== 1'b1 && s[SUC_ST_BADRES] !== 1'b1);
   endtask : wait_end
   function automatic logic [31:0] exp_word(input int k, input logic [31:0] im);
      logic [31:0] keep, frc;
      keep = 32'hFFFFFFF0; frc = 32'h0;
      case (k)
         7: begin keep = SUC_R7_KEEP; frc = SUC_R7_FORCE; end
         8: begin keep = 32'h0; frc = SUC_FIXED_R8; end
         10: begin keep = SUC_R10_KEEP; frc = SUC_R10_FORCE; end
         11: begin keep = 32'h0; frc = SUC_FIXED_R11; end
         12: begin keep = SUC_R12_KEEP; frc = SUC_R12_FORCE; end
         default: ;
      endcase
      return (im & keep) | frc | {28'h0, 4'(k)};
   endfunction : exp_word
   // ----------------------------------------
   // watcher and timeout
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (m_got === 1'b1) begin
         words_seen++;
         check("word expected", 32'h1, 32'(exp_q.size() > 0));
         if (exp_q.size() > 0) check("word", exp_q.pop_front(), m_word);
      end
      if (m_fa === 1'b1) check("apply on last word", 32'h0, 32'(exp_q.size()));
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         $display("MISMATCH timeout expected done seen hang");
         results();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin : main
      int k, v;
      void'($urandom(32'hB9CC));
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge core_clk);
      check("waitrequest idle", 32'h1, {31'h0, avs_waitrequest});
      check("latch idle", 32'h0, {31'h0, syn_latch});
      for (k = 0; k < SUC_NUM_WORDS; k++) begin
         img[k] = $urandom;
         if (k == 12) img[k][31:16] = 16'hFFFF;
         if (k == 9) img[k][13:4] = 10'h3FF;
         bus_wr(SUC_ADDR_WIDX, 32'(k));
         bus_wr(SUC_ADDR_WDATA, img[k]);
      end
      bus_wr(SUC_ADDR_WIDX, 32'h9);
      bus_rd(SUC_ADDR_WDATA, rd);
      check("image readback", img[9], rd);
      bus_rd(4'h2, rd);
      check("unmapped read", SUC_DEAD_DATA, rd);
      for (k = 12; k >= 0; k--) exp_q.push_back(exp_word(k, img[k]));
      bus_wr(SUC_ADDR_CTRL, 32'h1);
      wait_end(st);
      check("status full", 32'h2, st & 32'h6);
      check("words left", 32'h0, 32'(exp_q.size()));
      // single word six, both enable levels; a write during busy must be dropped
      for (v = 0; v < 2; v++) begin
         img[6] = $urandom;
         img[6][6] = v[0];
         img[6][5:4] = 2'(v + 1);
         bus_wr(SUC_ADDR_WIDX, 32'h6);
         bus_wr(SUC_ADDR_WDATA, img[6]);
         exp_q.push_back(exp_word(6, img[6]));
         bus_wr(SUC_ADDR_CTRL, 32'h3);
         bus_wr(SUC_ADDR_WDATA, ~img[6]);
         wait_end(st);
         check("output enable", {31'h0, img[6][6]}, {31'h0, m_en});
         check("output power", {30'h0, img[6][5:4]}, {30'h0, m_pwr});
         bus_rd(SUC_ADDR_WDATA, rd);
         check("write while busy", img[6], rd);
      end
      // zero resync divider: refused before anything leaves
      bus_wr(SUC_ADDR_WIDX, 32'hC);
      bus_wr(SUC_ADDR_WDATA, {16'h0, 16'($urandom)});
      k = words_seen;
      bus_wr(SUC_ADDR_CTRL, 32'h1);
      wait_end(st);
      check("bad resync flag", 32'h4, st & 32'h4);
      repeat (400) @(posedge core_clk);
      check("words after refusal", 32'(k), 32'(words_seen));
      results();
   end
endmodule : tb_top
bind suc_host suc_host_monitor u_mon (.core_clk(core_clk), .ce(ce), .rst_b(rst_b),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .syn_clk(syn_clk), .syn_data(syn_data),
   .syn_latch(syn_latch));
